// File: hdl/sqc_queue_cfg.sv
// Queue configuration block: transmit and receive queues, transfer requests and wake logic.
// What this block does
// - Bit 0 enables transmit queue, resets clear.
// - Bit 1 enables receive queue, resets clear.
// - Bits 5:4 read size code one.
// - Transmit request while enabled and not full.
// - Receive request while enabled and holding data.
// - Transmit wake at or below trigger level when enabled.
// - Receive wake above trigger level when enabled.
// - Wake bits clear: no level wake; reset clear.
// - Level wake serves transfer engine, never processor.
// - Reserved bits read zero, written zeros.
// - Bits 16, 17 flush queues, write-only.
// - Trigger levels come from trigger settings register.
`default_nettype none
module sqc_queue_cfg
    import sqc_pkg::*;
#(
    parameter int unsigned WIDTH = SQC_WIDTH,
    parameter int unsigned DEPTH = SQC_DEPTH
) (
    input wire logic clk, // Block clock, 25 MHz.
    input wire logic rst, // Asynchronous reset, high.
    input wire logic [SQC_AW-1:0] addr, // Register byte address.
    input wire logic [31:0] wdata, // Register write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [31:0] rdata, // Read data, cycle after rd.
    input wire logic tx_pop, // Shift engine takes a transmit word.
    output logic [WIDTH-1:0] tx_word, // Transmit word, valid with tx_word_valid.
    output logic tx_word_valid, // Pulse: tx_word holds the taken word.
    output logic tx_avail, // Transmit queue has a word to take.
    input wire logic [WIDTH-1:0] rx_in_data, // Received word from shift engine.
    input wire logic rx_in_valid, // Received word offered.
    output logic rx_in_ready, // Receive queue accepts a word.
    output logic dma_tx_req, // Transmit transfer request, level.
    output logic dma_rx_req, // Receive transfer request, level.
    output logic dma_wake, // Wake-up for transfer service only.
    output logic tx_level_hit, // Transmit level trigger for interrupt logic.
    output logic rx_level_hit // Receive level trigger for interrupt logic.
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [SQC_LW-1:0] FULL_CNT = SQC_LW'(DEPTH);

    logic [1:0] on_r;
    logic [1:0] dma_on_r;
    logic [1:0] wake_on_r;
    logic [1:0] lvlena_r;
    logic [SQC_LW-1:0] trig_r [2];
    logic [AW-1:0] wptr_r [2];
    logic [AW-1:0] rptr_r [2];
    logic [SQC_LW-1:0] cnt_r [2];
    logic [1:0] push;
    logic [1:0] pop;
    logic [1:0] flush;
    logic [1:0] full;
    logic [1:0] empty;
    logic [1:0] at_trig;
    logic [WIDTH-1:0] rd_q [2];
    logic [31:0] rdata_r;
    logic rx_sel_r;
    logic tx_word_valid_r;

    function automatic logic hit(input logic [SQC_AW-1:0] a, input logic [SQC_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction

    wire cfg_wr = wr && hit(addr, SQC_CFG_OFS);
    wire trig_wr = wr && hit(addr, SQC_TRIG_OFS);
    wire txd_wr = wr && hit(addr, SQC_TXDATA_OFS);
    wire rxd_rd = rd && hit(addr, SQC_RXDATA_OFS);

    // Flush commands act only on the write cycle and are never stored.
    assign flush[0] = cfg_wr && wdata[SQC_TX_FLUSH_BIT];
    assign flush[1] = cfg_wr && wdata[SQC_RX_FLUSH_BIT];

    // A transmit word written to a disabled or full queue is dropped, a received word is refused; flush wins over both.
    assign push[0] = txd_wr && on_r[0] && !full[0] && !flush[0];
    assign push[1] = rx_in_valid && rx_in_ready && !flush[1];
    assign pop[0] = tx_pop && tx_avail && !flush[0];
    assign pop[1] = rxd_rd && on_r[1] && !empty[1] && !flush[1];

    assign rx_in_ready = on_r[1] && !full[1];
    assign tx_avail = on_r[0] && !empty[0];

    genvar q;
    generate
        for (q = 0; q < 2; q++) begin : g_queue
            logic [SQC_LW-1:0] cnt_nxt;

            assign full[q] = (cnt_r[q] == FULL_CNT);
            assign empty[q] = (cnt_r[q] == '0);
            assign cnt_nxt = flush[q] ? '0 :
                cnt_r[q] + SQC_LW'(push[q]) - SQC_LW'(pop[q]);

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    wptr_r[q] <= '0;
                    rptr_r[q] <= '0;
                    cnt_r[q] <= '0;
                end else begin
                    cnt_r[q] <= cnt_nxt;
                    if (flush[q]) begin
                        wptr_r[q] <= '0;
                        rptr_r[q] <= '0;
                    end else begin
                        if (push[q]) begin
                            wptr_r[q] <= AW'(wptr_r[q] + 1'b1);
                        end
                        if (pop[q]) begin
                            rptr_r[q] <= AW'(rptr_r[q] + 1'b1);
                        end
                    end
                end
            end

            sqc_queue_mem #(
                .WIDTH(WIDTH),
                .DEPTH(DEPTH),
                .AW(AW)
            ) u_mem (
                .clk(clk),
                .rst(rst),
                .wr_en(push[q]),
                .wr_addr(wptr_r[q]),
                .wr_data(q == 0 ? wdata[WIDTH-1:0] : rx_in_data),
                .rd_en(pop[q]),
                .rd_addr(rptr_r[q]),
                .rd_data(rd_q[q])
            );
        end
    endgenerate

    // Configuration and trigger settings registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_r <= {2{SQC_ON_RST}};
            dma_on_r <= {2{SQC_ON_RST}};
            wake_on_r <= {2{SQC_ON_RST}};
            lvlena_r <= {2{SQC_ON_RST}};
            trig_r[0] <= SQC_TRIG_RST;
            trig_r[1] <= SQC_TRIG_RST;
        end else begin
            if (cfg_wr) begin
                on_r <= {wdata[SQC_RX_ON_BIT], wdata[SQC_TX_ON_BIT]};
                dma_on_r <= {wdata[SQC_RX_DMA_BIT], wdata[SQC_TX_DMA_BIT]};
                wake_on_r <= {wdata[SQC_RX_WAKE_BIT], wdata[SQC_TX_WAKE_BIT]};
            end
            if (trig_wr) begin
                lvlena_r <= {wdata[SQC_RX_LVLENA_BIT], wdata[SQC_TX_LVLENA_BIT]};
                trig_r[0] <= wdata[SQC_TX_TRIG_LSB +: SQC_LW];
                trig_r[1] <= wdata[SQC_RX_TRIG_LSB +: SQC_LW];
            end
        end
    end

    // Transfer requests follow the queue state with no added delay.
    assign dma_tx_req = dma_on_r[0] && on_r[0] && !full[0];
    assign dma_rx_req = dma_on_r[1] && on_r[1] && !empty[1];

    // Transmit triggers once drained to its level, receive once filled beyond it.
    assign at_trig[0] = on_r[0] && (cnt_r[0] <= trig_r[0]);
    assign at_trig[1] = on_r[1] && (cnt_r[1] > trig_r[1]);

    // The wake only starts transfer service; no processor wake leaves this block.
    assign dma_wake = |(wake_on_r & at_trig);
    assign tx_level_hit = lvlena_r[0] && at_trig[0];
    assign rx_level_hit = lvlena_r[1] && at_trig[1];

    // Read path; reserved and unmapped bits read as zero.
    wire [31:0] cfg_view = {
        16'h0000,
        wake_on_r[1], wake_on_r[0], dma_on_r[1], dma_on_r[0],
        6'h00, SQC_SIZE_CODE, 2'h0, on_r[1], on_r[0]
    };
    wire [31:0] stat_view = {
        12'h000, cnt_r[1], 4'h0, cnt_r[0], 4'h0,
        full[1], !empty[1], !full[0], empty[0]
    };
    wire [31:0] trig_view = {
        12'h000, trig_r[1], 4'h0, trig_r[0], 6'h00, lvlena_r
    };
    wire [31:0] rd_mux = hit(addr, SQC_CFG_OFS) ? cfg_view :
        hit(addr, SQC_STAT_OFS) ? stat_view :
        hit(addr, SQC_TRIG_OFS) ? trig_view : SQC_RD_RST;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= SQC_RD_RST;
            rx_sel_r <= 1'b0;
            tx_word_valid_r <= 1'b0;
        end else begin
            rdata_r <= rd ? rd_mux : SQC_RD_RST;
            rx_sel_r <= pop[1];
            tx_word_valid_r <= pop[0];
        end
    end

    // A receive word comes from the storage's own output register.
    assign rdata = rx_sel_r ? {{(32 - WIDTH){1'b0}}, rd_q[1]} : rdata_r;
    assign tx_word = rd_q[0];
    assign tx_word_valid = tx_word_valid_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_tx_enable_write: assert property (
        cfg_wr |=> on_r[0] == $past(wdata[SQC_TX_ON_BIT]) && tx_avail == (on_r[0] && cnt_r[0] != '0)
    ) else $error("tx queue enable does not follow write");

    chk_rx_enable_write: assert property (
        cfg_wr |=> rx_in_ready == ($past(wdata[SQC_RX_ON_BIT]) && !full[1])
    ) else $error("rx queue enable does not follow write");

    chk_size_code_read: assert property (
        rd && hit(addr, SQC_CFG_OFS) |=> rdata[5:4] == 2'h1
    ) else $error("size code not reported as one");

    chk_reserved_read_zero: assert property (
        rd && hit(addr, SQC_CFG_OFS) |=> rdata[3:2] == 2'h0 && rdata[11:6] == 6'h00
            && rdata[31:16] == 16'h0000
    ) else $error("reserved configuration bits not zero");

    chk_tx_request_full: assert property (
        dma_tx_req |-> cnt_r[0] < FULL_CNT && dma_on_r[0] && on_r[0]
    ) else $error("transmit request while full or disabled");

    chk_rx_request_data: assert property (
        dma_on_r[1] && on_r[1] && push[1] && !pop[1] && !cfg_wr |=> dma_rx_req
    ) else $error("receive request missing after data arrived");

    chk_wake_gated_bits: assert property (
        dma_wake |-> (wake_on_r[0] && cnt_r[0] <= trig_r[0])
            || (wake_on_r[1] && cnt_r[1] > trig_r[1])
    ) else $error("wake raised without enabled level trigger");

    chk_tx_wake_drain: assert property (
        wake_on_r[0] && on_r[0] && pop[0] && cnt_r[0] == trig_r[0] + 1'b1
            && !cfg_wr && !trig_wr && !push[0] |=> dma_wake
    ) else $error("transmit wake missing at trigger level");

    chk_flush_empties: assert property (
        cfg_wr && wdata[SQC_TX_FLUSH_BIT] && wdata[SQC_RX_FLUSH_BIT]
            |=> cnt_r[0] == '0 && cnt_r[1] == '0 && !dma_rx_req
    ) else $error("flush did not empty the queues");

    chk_rx_enable_bit: assert property (
        cfg_wr |=> on_r[1] == $past(wdata[SQC_RX_ON_BIT])
    ) else $error("rx enable bit does not follow write");

    chk_cfg_bits_hold: assert property (
        !cfg_wr |=> $stable(on_r) && $stable(dma_on_r) && $stable(wake_on_r)
    ) else $error("configuration bits changed without a write");

    chk_enable_read_back: assert property (
        rd && hit(addr, SQC_CFG_OFS) |=> rdata[1:0] == $past(on_r)
    ) else $error("enable bits read back wrong");

    chk_request_bits_read: assert property (
        rd && hit(addr, SQC_CFG_OFS) |=> rdata[15:12] == $past({wake_on_r, dma_on_r})
    ) else $error("request and wake bits read back wrong");

    chk_flush_bits_read: assert property (
        rd && hit(addr, SQC_CFG_OFS) |=> rdata[17:16] == 2'h0
    ) else $error("flush bits do not read as zero");

    chk_tx_request_off: assert property (
        !dma_on_r[0] || !on_r[0] |-> !dma_tx_req
    ) else $error("transmit request while request bit clear");

    chk_rx_request_off: assert property (
        !dma_on_r[1] || !on_r[1] |-> !dma_rx_req
    ) else $error("receive request while request bit clear");

    chk_rx_request_empty: assert property (
        dma_rx_req |-> cnt_r[1] != '0
    ) else $error("receive request while queue empty");

    chk_tx_request_room: assert property (
        dma_on_r[0] && on_r[0] && cnt_r[0] < FULL_CNT |-> dma_tx_req
    ) else $error("transmit request missing while room left");

    chk_rx_request_held: assert property (
        dma_on_r[1] && on_r[1] && cnt_r[1] != '0 |-> dma_rx_req
    ) else $error("receive request missing while data held");

    chk_wake_bits_clear: assert property (
        wake_on_r == 2'h0 |-> !dma_wake
    ) else $error("wake raised with both wake bits clear");

    chk_rx_wake_fill: assert property (
        wake_on_r[1] && on_r[1] && push[1] && !pop[1] && cnt_r[1] == trig_r[1]
            && !cfg_wr && !trig_wr |=> dma_wake
    ) else $error("receive wake missing at trigger level");

    chk_tx_flush_empties: assert property (
        cfg_wr && wdata[SQC_TX_FLUSH_BIT] |=> cnt_r[0] == '0 && !tx_avail
    ) else $error("transmit flush did not empty the queue");

    chk_rx_flush_empties: assert property (
        cfg_wr && wdata[SQC_RX_FLUSH_BIT] |=> cnt_r[1] == '0 && !dma_rx_req
    ) else $error("receive flush did not empty the queue");

    chk_tx_word_pulse: assert property (
        tx_word_valid == $past(pop[0])
    ) else $error("transmit word valid not one cycle after a take");

    chk_queue_depth: assert property (
        cnt_r[0] <= FULL_CNT && cnt_r[1] <= FULL_CNT
    ) else $error("queue holds more than eight words");

    chk_tx_full_drop: assert property (
        txd_wr && full[0] && !pop[0] |=> full[0]
    ) else $error("write to a full transmit queue changed its level");

    chk_rx_off_refuse: assert property (
        !on_r[1] |-> !rx_in_ready && !dma_rx_req
    ) else $error("disabled receive queue accepts or requests");

    chk_tx_off_idle: assert property (
        !on_r[0] |-> !tx_avail && !dma_tx_req
    ) else $error("disabled transmit queue offers or requests");

    chk_tx_level_src: assert property (
        tx_level_hit |-> lvlena_r[0] && on_r[0] && cnt_r[0] <= trig_r[0]
    ) else $error("transmit level trigger without its setting");

    chk_rx_level_src: assert property (
        rx_level_hit |-> lvlena_r[1] && on_r[1] && cnt_r[1] > trig_r[1]
    ) else $error("receive level trigger without its setting");

    chk_trig_write: assert property (
        trig_wr |=> trig_r[0] == $past(wdata[SQC_TX_TRIG_LSB +: SQC_LW])
            && trig_r[1] == $past(wdata[SQC_RX_TRIG_LSB +: SQC_LW])
    ) else $error("trigger levels do not follow write");

    chk_tx_wake_nolevel: assert property (
        wake_on_r[0] && on_r[0] && cnt_r[0] <= trig_r[0] |-> dma_wake
    ) else $error("transmit wake missing without level enable");

    chk_rx_wake_nolevel: assert property (
        wake_on_r[1] && on_r[1] && cnt_r[1] > trig_r[1] |-> dma_wake
    ) else $error("receive wake missing without level enable");

    chk_rx_empty_read: assert property (
        rxd_rd && !pop[1] |=> rdata == 32'h0000_0000
    ) else $error("refused receive read returned data");
endmodule
`default_nettype wire

// File: common/sqc_pkg.sv
// Package: register map, field positions, reset values and sizes of the queue block.
`default_nettype none
package sqc_pkg;
    localparam int unsigned SQC_AW = 12;
    localparam logic [11:0] SQC_CFG_OFS = 12'hE00;
    localparam logic [11:0] SQC_STAT_OFS = 12'hE04;
    localparam logic [11:0] SQC_TRIG_OFS = 12'hE08;
    localparam logic [11:0] SQC_TXDATA_OFS = 12'hE20;
    localparam logic [11:0] SQC_RXDATA_OFS = 12'hE30;
    // Configuration register fields.
    localparam int unsigned SQC_TX_ON_BIT = 0;
    localparam int unsigned SQC_RX_ON_BIT = 1;
    localparam int unsigned SQC_SIZE_LSB = 4;
    localparam int unsigned SQC_TX_DMA_BIT = 12;
    localparam int unsigned SQC_RX_DMA_BIT = 13;
    localparam int unsigned SQC_TX_WAKE_BIT = 14;
    localparam int unsigned SQC_RX_WAKE_BIT = 15;
    localparam int unsigned SQC_TX_FLUSH_BIT = 16;
    localparam int unsigned SQC_RX_FLUSH_BIT = 17;
    localparam logic [1:0] SQC_SIZE_CODE = 2'h1;
    // Trigger settings register fields.
    localparam int unsigned SQC_TX_LVLENA_BIT = 0;
    localparam int unsigned SQC_RX_LVLENA_BIT = 1;
    localparam int unsigned SQC_TX_TRIG_LSB = 8;
    localparam int unsigned SQC_RX_TRIG_LSB = 16;
    // Status register fields.
    localparam int unsigned SQC_ST_TXEMPTY_BIT = 0;
    localparam int unsigned SQC_ST_TXNOTFULL_BIT = 1;
    localparam int unsigned SQC_ST_RXNOTEMPTY_BIT = 2;
    localparam int unsigned SQC_ST_RXFULL_BIT = 3;
    localparam int unsigned SQC_ST_TX_TRIGGER_LEVEL_LSB = 8;
    localparam int unsigned SQC_ST_RX_TRIGGER_LEVEL_LSB = 16;
    // Queue geometry and reset values.
    localparam int unsigned SQC_DEPTH = 8;
    localparam int unsigned SQC_WIDTH = 16;
    localparam int unsigned SQC_LW = 4;
    localparam logic SQC_ON_RST = 1'b0;
    localparam logic [3:0] SQC_TRIG_RST = 4'h0;
    localparam logic [31:0] SQC_RD_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// File: hdl/sqc_queue_mem.sv
// Two-port storage for one queue, with registered read data.
`default_nettype none
module sqc_queue_mem #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW = 3
) (
    input wire logic clk, // Block clock.
    input wire logic rst, // Asynchronous reset, high.
    input wire logic wr_en, // Store wr_data at wr_addr.
    input wire logic [AW-1:0] wr_addr, // Write location.
    input wire logic [WIDTH-1:0] wr_data, // Word to store.
    input wire logic rd_en, // Fetch word at rd_addr.
    input wire logic [AW-1:0] rd_addr, // Read location.
    output logic [WIDTH-1:0] rd_data // Word from the last fetch, held until the next.
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule
`default_nettype wire

// File: tb/sqc_shift_model.sv
// Model of the serial shift engine that takes transmit words and offers received words.
`default_nettype none
module sqc_shift_model
    import sqc_pkg::*;
(
    input wire logic clk, // Block clock.
    input wire logic rst, // Asynchronous reset, high.
    input wire logic pop_go, // Bench allows taking transmit words.
    input wire logic push_go, // Bench allows offering received words.
    input wire logic tx_avail, // Transmit queue has a word.
    output logic tx_pop, // Take one transmit word.
    input wire logic rx_in_ready, // Receive queue accepts a word.
    output logic rx_in_valid, // Received word offered.
    output logic [SQC_WIDTH-1:0] rx_in_data // Offered word.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SQC_WIDTH-1:0] seq_r;
    assign tx_pop = pop_go && tx_avail;
    // An offer is held until taken; between offers the data line keeps toggling.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_in_valid <= 1'h0;
            rx_in_data <= 16'h5A5A;
            seq_r <= 16'hA000;
        end else if (rx_in_valid && !rx_in_ready) begin
            rx_in_valid <= 1'h1;
        end else if (push_go) begin
            rx_in_valid <= 1'h1;
            rx_in_data <= seq_r;
            seq_r <= seq_r + 16'h1;
        end else begin
            rx_in_valid <= 1'h0;
            rx_in_data <= ~rx_in_data;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Testbench of the queue configuration block with a shift engine model.
`default_nettype none
module tb_top
    import sqc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, rd, pop_go, push_go, tx_pop, tx_word_valid, tx_avail;
    logic rx_in_valid, rx_in_ready, dma_tx_req, dma_rx_req, dma_wake, tx_level_hit, rx_level_hit;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [15:0] tx_word, rx_in_data;
    logic [15:0] got[$];
    int err_count, checks, n;
    logic [31:0] row_w [7] = '{32'h1, 32'h1001, 32'h1000, 32'h2002, 32'hF003, 32'h4000,
        32'hFFFC_0FCC};
    logic [31:0] row_r [7] = '{32'h11, 32'h1011, 32'h1010, 32'h2012, 32'hF013, 32'h4010, 32'h10};
    logic [2:0] row_f [7] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h5, 3'h0, 3'h0};

    sqc_queue_cfg dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .tx_pop, .tx_word,
        .tx_word_valid, .tx_avail, .rx_in_data, .rx_in_valid, .rx_in_ready, .dma_tx_req,
        .dma_rx_req, .dma_wake, .tx_level_hit, .rx_level_hit);
    sqc_shift_model far (.clk, .rst, .pop_go, .push_go, .tx_avail, .tx_pop, .rx_in_ready,
        .rx_in_valid, .rx_in_data);

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tx_word_valid === 1'h1) got.push_back(tx_word);
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic bw(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask
    task automatic br(input logic [11:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #(40 * 4000);
        err_count++;
        results();
    end

    initial begin
        rst = 1'h1; wr = 1'h0; rd = 1'h0; addr = 12'h0; wdata = 32'h0;
        pop_go = 1'h0; push_go = 1'h0; err_count = 0; checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        br(SQC_CFG_OFS); chk("cfg_rst", 32'h10, d);
        br(SQC_STAT_OFS); chk("stat_rst", 32'h3, d);
        br(SQC_TRIG_OFS); chk("trig_rst", 32'h0, d);
        br(12'hE10); chk("unmapped", 32'h0, d);
        chk("rst_out", 32'h0, {27'h0, dma_tx_req, dma_rx_req, dma_wake, tx_avail, rx_in_ready});
        for (int i = 0; i < 7; i++) begin
            bw(SQC_CFG_OFS, row_w[i]);
            br(SQC_CFG_OFS); chk("cfg", row_r[i], d);
            chk("req_wake", {29'h0, row_f[i]}, {29'h0, dma_tx_req, dma_rx_req, dma_wake});
        end
        bw(SQC_CFG_OFS, 32'h1001);
        for (int i = 0; i < 9; i++) bw(SQC_TXDATA_OFS, 32'hB000 + 32'(i));
        br(SQC_STAT_OFS); chk("tx_full", 32'h800, d);
        chk("tx_req_full", 32'h0, {31'h0, dma_tx_req});
        bw(SQC_TRIG_OFS, 32'h701);
        bw(SQC_CFG_OFS, 32'h5001);
        chk("tx_wake7", 32'h0, {30'h0, tx_level_hit, dma_wake});
        bw(SQC_TRIG_OFS, 32'h800);
        chk("tx_wake8", 32'h1, {30'h0, tx_level_hit, dma_wake});
        bw(SQC_TRIG_OFS, 32'h801);
        bw(SQC_CFG_OFS, 32'h1001);
        chk("wake_off", 32'h2, {30'h0, tx_level_hit, dma_wake});
        bw(SQC_TRIG_OFS, 32'h301);
        bw(SQC_CFG_OFS, 32'h5001);
        chk("tx_wake_hi", 32'h0, {30'h0, tx_level_hit, dma_wake});
        @(posedge clk);
        pop_go <= 1'h1;
        n = 0;
        while (tx_avail !== 1'h0 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        pop_go <= 1'h0;
        repeat (2) @(posedge clk);
        chk("tx_cnt", 32'h8, 32'(got.size()));
        foreach (got[i]) chk("tx_word", 32'hB000 + 32'(i), {16'h0, got[i]});
        chk("tx_req", 32'h1, {31'h0, dma_tx_req});
        chk("tx_wake3", 32'h3, {30'h0, tx_level_hit, dma_wake});
        bw(SQC_TXDATA_OFS, 32'h1);
        bw(SQC_TXDATA_OFS, 32'h2);
        bw(SQC_CFG_OFS, 32'h1_1001);
        br(SQC_STAT_OFS); chk("tx_flush", 32'h3, d);
        br(SQC_CFG_OFS); chk("flush_rd", 32'h1011, d);
        bw(SQC_TRIG_OFS, 32'h8_0002);
        bw(SQC_CFG_OFS, 32'hA002);
        @(posedge clk);
        push_go <= 1'h1;
        n = 0;
        while (rx_in_ready !== 1'h0 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        push_go <= 1'h0;
        br(SQC_STAT_OFS); chk("rx_full", 32'h8_000F, d);
        chk("rx_req", 32'h1, {31'h0, dma_rx_req});
        chk("rx_wake8", 32'h0, {30'h0, rx_level_hit, dma_wake});
        bw(SQC_TRIG_OFS, 32'h7_0002);
        chk("rx_wake7", 32'h3, {30'h0, rx_level_hit, dma_wake});
        for (int i = 0; i < 9; i++) begin
            br(SQC_RXDATA_OFS); chk("rx_word", 32'hA000 + 32'(i), d);
        end
        br(SQC_RXDATA_OFS); chk("rx_empty_rd", 32'h0, d);
        chk("rx_req_off", 32'h0, {31'h0, dma_rx_req});
        bw(SQC_CFG_OFS, 32'h3003);
        bw(SQC_TXDATA_OFS, 32'h5);
        @(posedge clk);
        push_go <= 1'h1;
        @(posedge clk);
        push_go <= 1'h0;
        br(SQC_STAT_OFS); chk("pre_flush", 32'h1_0106, d);
        bw(SQC_CFG_OFS, 32'h3_3003);
        br(SQC_STAT_OFS); chk("both_flush", 32'h3, d);
        chk("flush_req", 32'h2, {30'h0, dma_tx_req, dma_rx_req});
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        br(SQC_CFG_OFS); chk("cfg_rst2", 32'h10, d);
        results();
    end
endmodule
`default_nettype wire
